// File: design/bcs_pkg.sv
// Constants and types of the bridge configuration status bank
// What this block does
// R1: Pending interrupt from the bridge function itself sets the pending status bit 3.
// R2: Interrupts forwarded from downstream devices never touch the pending bit.
// R3: Downstream port: an asserted hot-plug interrupt sets the pending bit.
// R4: Upstream port: internal parity or config access error sets the pending bit.
// R5: Capabilities-list bit 4 always reads one.
// R6: Bit 8 sets on poisoned completion in or poisoned write out, when enabled.
// R7: Bit 14 sets when a fatal or non-fatal message is sent with error enable.
// R8: Bit 15 sets on any poisoned packet received, enable ignored; write one clears.
// R9: Target abort and master abort bits 11 to 13 always read zero.
// R10: Bits 5, 7 and the timing field 10:9 are read-only zero.
// R11: Revision register holds an 8-bit number in 7:0, writes blocked once locked.
// R12: Parity enable, command bit 6, gates bit 8; clear means never set.
// R13: Error enable, command bit 8, gates fatal and non-fatal error reporting.
// R14: Write one clears a flag, zero keeps it; a same-cycle set wins.
package bcs_pkg;
  // Status and revision offsets are word indices; byte address is four times the index
  localparam logic [7:0] BCS_STATUS_IDX = 8'h06;
  localparam logic [7:0] BCS_REV_IDX = 8'h08;
  localparam logic [7:0] BCS_CMD_ADDR = 8'h40;
  localparam logic [7:0] BCS_CFG_ADDR = 8'h44;
  localparam logic [7:0] BCS_EVT_ADDR = 8'h48;
  localparam logic [7:0] BCS_MASK_ADDR = 8'h4C;
  // Status bit positions
  localparam int BCS_ST_INTP = 3;
  localparam int BCS_ST_CAP = 4;
  localparam int BCS_ST_MPOI = 8;
  localparam int BCS_ST_SYSERR = 14;
  localparam int BCS_ST_PSEEN = 15;
  // Command bit positions
  localparam int BCS_CMD_PERR = 6;
  localparam int BCS_CMD_SERR = 8;
  // Port configuration bit positions
  localparam int BCS_CFG_DOWN = 0;
  localparam int BCS_CFG_LOCK = 1;
  // Event status bit positions
  localparam int BCS_EV_MPOI = 0;
  localparam int BCS_EV_SYSERR = 1;
  localparam int BCS_EV_PSEEN = 2;
  localparam int BCS_EV_PAR = 3;
  localparam int BCS_EV_CFGE = 4;
  localparam int BCS_EV_HP = 5;
  localparam int BCS_EV_W = 6;
  // Reset values
  localparam logic [15:0] BCS_STATUS_RST = 16'h0000;
  localparam logic [15:0] BCS_CMD_RST = 16'h0000;
  localparam logic [7:0] BCS_REV_RST = 8'h00;
  localparam logic [BCS_EV_W-1:0] BCS_EV_RST = 6'h00;
  // Event inputs from the port core, all pulses except the two levels
  typedef struct packed {
    logic own_intx;
    logic hp_irq;
    logic parity_err;
    logic cfg_err;
    logic poison_cpl_rx;
    logic poison_wr_tx;
    logic err_msg_tx;
    logic poison_tlp_rx;
  } bcs_evt_t;
endpackage

// File: design/bcs_top.sv
// Status and revision register bank of a switch bridge header, Wishbone slave
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module bcs_top #(
  parameter int AW = 8,
  // Arbitrary revision value
  parameter logic [7:0] REV_INIT = 8'h00
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [AW-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic O_WB_ACK,
  output logic [31:0] O_WB_DAT,
  // Port core events
  input wire bcs_pkg::bcs_evt_t I_EVT,
  // Interrupt and status out
  output logic O_IRQ,
  output logic O_IRQ_PENDING
);
  logic ack_q;
  logic [31:0] dat_q;
  logic [15:0] status_q;
  logic [15:0] cmd_q;
  logic [7:0] rev_q;
  logic down_q;
  logic lock_q;
  logic [bcs_pkg::BCS_EV_W-1:0] evt_q;
  logic [bcs_pkg::BCS_EV_W-1:0] mask_q;
  logic irq_q;
  logic hp_prev_q;
  logic req;
  logic wr;
  logic [AW-1:0] adr;
  logic [31:0] wmask;
  logic [31:0] wclr;
  logic [31:0] rd;
  logic set_mpoi;
  logic set_syserr;
  logic set_pseen;
  logic [bcs_pkg::BCS_EV_W-1:0] ev_set;
  logic pend_d;
  // Request and event helpers
  logic take;
  logic hp_rise;
  logic irq_d;
  // Register decode and write strobes
  logic hit_status;
  logic hit_rev;
  logic hit_cmd;
  logic hit_cfg;
  logic hit_evt;
  logic hit_mask;
  logic wr_status;
  logic wr_rev;
  logic wr_cmd;
  logic wr_cfg;
  logic wr_evt;
  logic wr_mask;
  // Status flag clears
  logic clr_mpoi;
  logic clr_syserr;
  logic clr_pseen;

  assign req = I_WB_CYC & I_WB_STB;
  // Writes land on the edge where the master sees ack
  assign wr = req & I_WB_WE & ack_q;
  assign adr = I_WB_ADR;
  assign wmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
  assign wclr = I_WB_DAT & wmask;

  // A held strobe is not taken again in its own ack cycle
  assign take = req & ~ack_q;

  // Address decode for the write strobes; the read mux decodes the address in its own case
  assign hit_status = adr == AW'({bcs_pkg::BCS_STATUS_IDX, 2'b00});
  assign hit_rev = adr == AW'({bcs_pkg::BCS_REV_IDX, 2'b00});
  assign hit_cmd = adr == AW'(bcs_pkg::BCS_CMD_ADDR);
  assign hit_cfg = adr == AW'(bcs_pkg::BCS_CFG_ADDR);
  assign hit_evt = adr == AW'(bcs_pkg::BCS_EVT_ADDR);
  assign hit_mask = adr == AW'(bcs_pkg::BCS_MASK_ADDR);
  // Revision, config, event and mask fields sit in lane 0; command and status lanes are judged per bit
  assign wr_status = wr & hit_status;
  assign wr_rev = wr & hit_rev & I_WB_SEL[0];
  assign wr_cmd = wr & hit_cmd;
  assign wr_cfg = wr & hit_cfg & I_WB_SEL[0];
  assign wr_evt = wr & hit_evt & I_WB_SEL[0];
  assign wr_mask = wr & hit_mask & I_WB_SEL[0];
  // R14 clear on enabled lanes
  assign clr_mpoi = wr_status & wclr[bcs_pkg::BCS_ST_MPOI];
  assign clr_syserr = wr_status & wclr[bcs_pkg::BCS_ST_SYSERR];
  assign clr_pseen = wr_status & wclr[bcs_pkg::BCS_ST_PSEEN];

  // R12 parity enable gate
  // R6 master poison set
  assign set_mpoi = cmd_q[bcs_pkg::BCS_CMD_PERR] & (I_EVT.poison_cpl_rx | I_EVT.poison_wr_tx);
  // R13 error enable gate
  // R7 system error set
  assign set_syserr = cmd_q[bcs_pkg::BCS_CMD_SERR] & I_EVT.err_msg_tx;
  // R8 ungated poison set
  assign set_pseen = I_EVT.poison_tlp_rx;
  // History resets to the idle level, so reset raises no false edge
  assign hp_rise = I_EVT.hp_irq & ~hp_prev_q;

  always_comb
  begin
    ev_set = '0;
    ev_set[bcs_pkg::BCS_EV_MPOI] = set_mpoi;
    ev_set[bcs_pkg::BCS_EV_SYSERR] = set_syserr;
    ev_set[bcs_pkg::BCS_EV_PSEEN] = set_pseen;
    ev_set[bcs_pkg::BCS_EV_PAR] = I_EVT.parity_err;
    ev_set[bcs_pkg::BCS_EV_CFGE] = I_EVT.cfg_err;
    ev_set[bcs_pkg::BCS_EV_HP] = hp_rise;
  end

  // R1 own interrupt pending
  // R2 forwarded interrupts excluded
  always_comb
  begin
    pend_d = I_EVT.own_intx;
    if (down_q)
    begin
      // R3 hot-plug asserted
      pend_d = pend_d | I_EVT.hp_irq;
    end
    else
    begin
      // R4 latched internal errors
      pend_d = pend_d | evt_q[bcs_pkg::BCS_EV_PAR] | evt_q[bcs_pkg::BCS_EV_CFGE];
    end
  end

  // Bus handshake: one wait state, ack drops the cycle after it is given
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      ack_q <= 1'b0;
    else
      ack_q <= take;
  end

  always_comb
  begin
    rd = '0;
    case (adr)
      AW'({bcs_pkg::BCS_STATUS_IDX, 2'b00}):
        rd[15:0] = status_q;
      AW'({bcs_pkg::BCS_REV_IDX, 2'b00}):
        rd[7:0] = rev_q;
      bcs_pkg::BCS_CMD_ADDR:
        rd[15:0] = cmd_q;
      bcs_pkg::BCS_CFG_ADDR:
      begin
        rd[bcs_pkg::BCS_CFG_DOWN] = down_q;
        rd[bcs_pkg::BCS_CFG_LOCK] = lock_q;
      end
      bcs_pkg::BCS_EVT_ADDR:
        rd[bcs_pkg::BCS_EV_W-1:0] = evt_q;
      bcs_pkg::BCS_MASK_ADDR:
        rd[bcs_pkg::BCS_EV_W-1:0] = mask_q;
      // Unmapped reads return zero
      default:
        rd = '0;
    endcase
  end

  // Read data captured with ack so it stands exactly in the ack cycle
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      dat_q <= '0;
    else if (take & ~I_WB_WE)
      dat_q <= rd;
    else
      dat_q <= '0;
  end

  // Status register; untouched bits hold their reset value forever, zero except bit 4
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
    begin
      status_q <= bcs_pkg::BCS_STATUS_RST;
      // R5 capability list hardwired
      status_q[bcs_pkg::BCS_ST_CAP] <= 1'b1;
    end
    else
    begin
      // R9 abort bits stay zero
      // R10 inapplicable bits zero
      status_q[bcs_pkg::BCS_ST_INTP] <= pend_d;
      // R14 set beats clear
      if (set_mpoi)
        status_q[bcs_pkg::BCS_ST_MPOI] <= 1'b1;
      else if (clr_mpoi)
        status_q[bcs_pkg::BCS_ST_MPOI] <= 1'b0;
      // R14 set beats clear
      if (set_syserr)
        status_q[bcs_pkg::BCS_ST_SYSERR] <= 1'b1;
      else if (clr_syserr)
        status_q[bcs_pkg::BCS_ST_SYSERR] <= 1'b0;
      // R14 set beats clear
      if (set_pseen)
        status_q[bcs_pkg::BCS_ST_PSEEN] <= 1'b1;
      else if (clr_pseen)
        status_q[bcs_pkg::BCS_ST_PSEEN] <= 1'b0;
    end
  end

  // Command enables; only the two bits this bank uses are writable
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      cmd_q <= bcs_pkg::BCS_CMD_RST;
    else if (wr_cmd)
    begin
      if (I_WB_SEL[0])
        cmd_q[bcs_pkg::BCS_CMD_PERR] <= I_WB_DAT[bcs_pkg::BCS_CMD_PERR];
      if (I_WB_SEL[1])
        cmd_q[bcs_pkg::BCS_CMD_SERR] <= I_WB_DAT[bcs_pkg::BCS_CMD_SERR];
    end
  end

  // Port role, carried in lane 0
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      down_q <= 1'b0;
    else if (wr_cfg)
      down_q <= I_WB_DAT[bcs_pkg::BCS_CFG_DOWN];
  end

  // Revision lock only sets; a reset is the one way to reopen the revision
  // Writing zero to the lock bit is harmless, so role updates never unlock
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      lock_q <= 1'b0;
    else if (wr_cfg && I_WB_DAT[bcs_pkg::BCS_CFG_LOCK])
      lock_q <= 1'b1;
  end

  // R11 revision with lock
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      rev_q <= REV_INIT;
    else if (wr_rev && !lock_q)
      rev_q <= I_WB_DAT[7:0];
  end

  // Hot-plug level history for the rising-edge event
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      hp_prev_q <= 1'b0;
    else
      hp_prev_q <= I_EVT.hp_irq;
  end

  // Sticky events pile up until software clears them
  // R14 set beats clear
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      evt_q <= bcs_pkg::BCS_EV_RST;
    else if (wr_evt)
      evt_q <= (evt_q & ~wclr[bcs_pkg::BCS_EV_W-1:0]) | ev_set;
    else
      evt_q <= evt_q | ev_set;
  end

  // Event mask, one bit per event status bit
  // A masked event still latches, so software can poll it
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      mask_q <= bcs_pkg::BCS_EV_RST;
    else if (wr_mask)
      mask_q <= I_WB_DAT[bcs_pkg::BCS_EV_W-1:0];
  end

  // Level interrupt, one cycle behind the status it reflects
  assign irq_d = |(evt_q & mask_q);
  always_ff @(posedge I_SYS_CLK)
  begin
    if (!I_RST_N)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = dat_q;
  assign O_IRQ = irq_q;
  assign O_IRQ_PENDING = status_q[bcs_pkg::BCS_ST_INTP];
endmodule

// File: dv/bcs_top_asserts.sv
// Port checks of the bridge status bank
`timescale 1ns/1ps
module bcs_asserts #(
  parameter int AW = 8
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [AW-1:0] I_WB_ADR,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire bcs_pkg::bcs_evt_t I_EVT,
  input wire logic O_IRQ_PENDING
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);
  logic st_rd;
  // Address is still held in the ack cycle
  assign st_rd = O_WB_ACK && !I_WB_WE && I_WB_ADR == 8'h18;
  ack_timing_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack missing after request");
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  idle_dat_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0000_0000)
    else $error("read data outside ack");
  rev_width_a: assert property (O_WB_ACK && !I_WB_WE && I_WB_ADR == 8'h20
    |-> O_WB_DAT[31:8] == 24'h00_0000)
    else $error("revision wider than a byte");
  own_pend_a: assert property (I_EVT.own_intx |=> O_IRQ_PENDING)
    else $error("pending bit missed own interrupt");
  cap_bit_a: assert property (st_rd |-> O_WB_DAT[4] == 1'b1)
    else $error("capability bit not one");
  abort_zero_a: assert property (st_rd |-> O_WB_DAT[13:11] == 3'h0)
    else $error("abort bits not zero");
  ro_zero_a: assert property (st_rd |-> {O_WB_DAT[10:9], O_WB_DAT[7], O_WB_DAT[5]} == 4'h0)
    else $error("fixed bits not zero");
endmodule
bind bcs_top bcs_asserts #(.AW(AW)) u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_EVT(I_EVT), .O_IRQ_PENDING(O_IRQ_PENDING));

// File: dv/bcs_top_bench.sv
// Self-checking bench of the bridge status bank
`timescale 1ns/1ps
module bcs_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic ack, irq, pend;
  logic [31:0] rdat, q;
  bcs_pkg::bcs_evt_t evt = '0;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  bcs_top DUT (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_ACK(ack),
    .O_WB_DAT(rdat), .I_EVT(evt), .O_IRQ(irq), .O_IRQ_PENDING(pend));
  task automatic conclude;
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until ack is sampled, then released for a cycle
  task automatic wbs(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wbs(w, a, d, 4'hF);
  endtask
  // Status is a 16-bit register, upper half not judged
  task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    check(n, e, (a == 8'h18) ? (q & 32'h0000_FFFF) : q);
  endtask
  task automatic pulse(input bcs_pkg::bcs_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask
  task automatic t_reset;
    rd(8'h18, "status", 32'h0000_0010);
    rd(8'h20, "revision", 32'h0000_0000);
    wb(1'b1, 8'h7C, 32'hFFFF_FFFF);
    rd(8'h7C, "unmapped", 32'h0000_0000);
    check("irq", 32'h0, irq);
  endtask
  task automatic t_poison;
    pulse(8'h08);
    pulse(8'h01);
    rd(8'h18, "status", 32'h0000_8010);
    wb(1'b1, 8'h40, 32'h0000_0040);
    pulse(8'h04);
    rd(8'h18, "status", 32'h0000_8110);
    wb(1'b1, 8'h18, 32'h0000_0100);
    rd(8'h18, "status", 32'h0000_8010);
    wb(1'b1, 8'h18, 32'h0000_8000);
    rd(8'h18, "status", 32'h0000_0010);
  endtask
  task automatic t_serr;
    pulse(8'h02);
    rd(8'h18, "status", 32'h0000_0010);
    wb(1'b1, 8'h40, 32'h0000_0100);
    pulse(8'h02);
    rd(8'h18, "status", 32'h0000_4010);
    // Event held across the clearing write
    evt <= 8'h02;
    wb(1'b1, 8'h18, 32'h0000_4000);
    evt <= '0;
    rd(8'h18, "status", 32'h0000_4010);
    wb(1'b1, 8'h18, 32'h0000_4000);
    wb(1'b1, 8'h48, 32'h0000_003F);
  endtask
  task automatic t_irq;
    pulse(8'h20);
    rd(8'h18, "status", 32'h0000_0018);
    check("pending", 32'h1, pend);
    wb(1'b1, 8'h4C, 32'h0000_0008);
    rd(8'h48, "events", 32'h0000_0008);
    check("irq", 32'h1, irq);
    wb(1'b1, 8'h4C, 32'h0000_0000);
    rd(8'h48, "events", 32'h0000_0008);
    check("irq", 32'h0, irq);
    wb(1'b1, 8'h48, 32'h0000_0008);
    pulse(8'h10);
    rd(8'h18, "status", 32'h0000_0018);
    wb(1'b1, 8'h48, 32'h0000_0010);
    rd(8'h18, "status", 32'h0000_0010);
    wb(1'b1, 8'h44, 32'h0000_0001);
    evt <= 8'h40;
    rd(8'h18, "status", 32'h0000_0018);
    evt <= 8'h80;
    rd(8'h18, "status", 32'h0000_0018);
    evt <= '0;
    rd(8'h18, "status", 32'h0000_0010);
    rd(8'h48, "events", 32'h0000_0020);
    wb(1'b1, 8'h48, 32'h0000_003F);
  endtask
  task automatic t_rev;
    wb(1'b1, 8'h20, 32'h0000_005A);
    rd(8'h20, "revision", 32'h0000_005A);
    wb(1'b1, 8'h44, 32'h0000_0003);
    wb(1'b1, 8'h20, 32'h0000_00A5);
    rd(8'h20, "revision", 32'h0000_005A);
  endtask
  // Readback of own registers and byte-lane gating of a clear
  task automatic t_lanes;
    rd(8'h40, "command", 32'h0000_0100);
    rd(8'h44, "config", 32'h0000_0003);
    wb(1'b1, 8'h4C, 32'h0000_003F);
    rd(8'h4C, "mask", 32'h0000_003F);
    pulse(8'h01);
    wbs(1'b1, 8'h18, 32'h0000_8000, 4'h1);
    rd(8'h18, "status", 32'h0000_8010);
    check("irq", 32'h1, irq);
    wbs(1'b1, 8'h18, 32'h0000_8000, 4'h2);
    rd(8'h18, "status", 32'h0000_0010);
    wb(1'b1, 8'h48, 32'h0000_003F);
    rd(8'h48, "events", 32'h0000_0000);
    check("irq", 32'h0, irq);
  endtask
  // Mid-run reset reopens the locked revision
  task automatic t_rerun;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h20, "revision", 32'h0000_0000);
    rd(8'h44, "config", 32'h0000_0000);
    rd(8'h18, "status", 32'h0000_0010);
    wb(1'b1, 8'h20, 32'h0000_0033);
    rd(8'h20, "revision", 32'h0000_0033);
  endtask
  // A hung handshake ends the run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      mismatches++;
      conclude;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_poison;
    t_serr;
    t_irq;
    t_rev;
    t_lanes;
    t_rerun;
    conclude;
  end
endmodule
